// ===== pkg/fbe_pkg.sv
// Constants for the fieldbus enable and status bank
// Contract
// - One 32-bit layout: bits 0-6 interfaces, bits 16-18 protocols.
// - Software switches interfaces and protocols by writing the control word; this build lets it switch only CAN (bit 3).
// - Disable-mask word has 1 for each deactivatable interface or protocol.
// - Enabled word shows the present activation state, not the request.
// - Status array is read-only: count reads 02, then mask, then enabled.
// - Reset status: mask 0000008 (CAN only), enabled 00190009.
// - Control word is 32-bit read/write, resets to 00190009, not mappable.
package fbe_pkg;
  localparam int unsigned FBE_AW = 4;
  localparam int unsigned FBE_DW = 32;
  // Byte addresses of the word registers
  localparam logic [3:0] FBE_OFS_CTRL = 4'h0;
  localparam logic [3:0] FBE_OFS_COUNT = 4'h4;
  localparam logic [3:0] FBE_OFS_MASK = 4'h8;
  localparam logic [3:0] FBE_OFS_ACTIVE = 4'hc;
  // Bit positions of the shared layout
  localparam int unsigned FBE_BIT_USB = 0;
  localparam int unsigned FBE_BIT_RS485 = 1;
  localparam int unsigned FBE_BIT_RS232 = 2;
  localparam int unsigned FBE_BIT_CAN = 3;
  localparam int unsigned FBE_BIT_WIRED_NETWORK_IFACE = 4;
  localparam int unsigned FBE_BIT_INDUSTRIAL_NETWORK_IFACE = 5;
  localparam int unsigned FBE_BIT_SPI = 6;
  localparam int unsigned FBE_BIT_SERIAL_BUS_PROTOCOL = 16;
  localparam int unsigned FBE_BIT_NETWORKED_BUS_PROTOCOL = 17;
  localparam int unsigned FBE_BIT_INDUSTRIAL_IP_PROTOCOL = 18;
  localparam logic [31:0] FBE_DEFINED_BITS = 32'h0007007f;
  // Reset values
  localparam logic [7:0] FBE_RST_COUNT = 8'h02;
  localparam logic [31:0] FBE_RST_MASK = 32'h00000008;
  localparam logic [31:0] FBE_RST_ACTIVE = 32'h00190009;
  localparam logic [31:0] FBE_RST_CTRL = 32'h00190009;
  localparam logic [31:0] FBE_UNMAPPED_DATA = 32'h00000000;
endpackage

// ===== pkg/fbe_reg_if.sv
// Carrier between bus slave and switch core
`timescale 1ns/1ps
interface fbe_reg_if;
  logic wr_ctrl;
  logic [31:0] wdata;
  logic [31:0] ctrl;
  logic [31:0] mask;
  logic [31:0] active;
  modport slave(output wr_ctrl, output wdata, input ctrl, input mask,
    input active);
  modport core(input wr_ctrl, input wdata, output ctrl, output mask,
    output active);
endinterface

// ===== rtl/fbe_switch_core.sv
// Control word, deactivation guard and active state per bit
`timescale 1ns/1ps
module fbe_switch_core
  import fbe_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  fbe_reg_if.core rif
);
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] active_q;
  logic [31:0] mask_w;
  logic [31:0] guarded_w;

  // Deactivation is fixed by the build; only CAN may be switched
  assign mask_w = FBE_RST_MASK;
  // Bits not in the mask keep their reset level
  assign guarded_w = (rif.wdata & mask_w) | (FBE_RST_CTRL & ~mask_w);
  assign ctrl_d = rif.wr_ctrl ? guarded_w : ctrl_q;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_q <= FBE_RST_CTRL;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Active state follows the stored request one cycle later; locked
  // bits never leave their reset level, so all 32 bits mirror ctrl_q
  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_bit
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          active_q[i] <= FBE_RST_ACTIVE[i];
        end else begin
          active_q[i] <= ctrl_q[i];
        end
      end
    end
  endgenerate

  assign rif.ctrl = ctrl_q;
  assign rif.mask = mask_w;
  assign rif.active = active_q;

  chk_active_follows: assert property (@(posedge clk_in) disable iff (!nrst_in)
    1'b1 |=> active_q == $past(ctrl_q))
    else $error("active flags do not follow control");
  chk_locked_stays: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (ctrl_q & ~mask_w & FBE_DEFINED_BITS) ==
    (FBE_RST_CTRL & ~mask_w & FBE_DEFINED_BITS))
    else $error("locked control bit changed");
  chk_locked_active: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ##1 (active_q[FBE_BIT_USB] && active_q[FBE_BIT_SERIAL_BUS_PROTOCOL]))
    else $error("locked interface went inactive");
  chk_can_switch: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rif.wr_ctrl |=> ##1
    active_q[FBE_BIT_CAN] == $past(rif.wdata[FBE_BIT_CAN], 2))
    else $error("CAN did not switch as written");
  chk_mask_const: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rif.mask == 32'h00000008)
    else $error("disable mask wrong");
endmodule

// ===== rtl/fbe_bank.sv
// Avalon-MM register bank for fieldbus enable control and status
`timescale 1ns/1ps
module fbe_bank
  import fbe_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [fbe_pkg::FBE_AW-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [fbe_pkg::FBE_DW-1:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [fbe_pkg::FBE_DW-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic avs_readdatavalid_out,
  output logic [31:0] active_flags_out
);
  import fbe_pkg::*;

  fbe_reg_if rif();

  typedef enum logic [0:0] {FBE_IDLE, FBE_DONE} fbe_state_e;
  fbe_state_e state_q;
  fbe_state_e state_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rvalid_q;
  logic req_w;
  logic hit_ctrl_w;
  logic hit_count_w;
  logic hit_mask_w;
  logic hit_active_w;
  logic [31:0] be_mask_w;
  logic [31:0] read_mux_w;

  fbe_switch_core fbe_switch_core_i (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .rif(rif)
  );

  assign req_w = avs_read_in | avs_write_in;
  assign hit_ctrl_w = avs_address_in == FBE_OFS_CTRL;
  assign hit_count_w = avs_address_in == FBE_OFS_COUNT;
  assign hit_mask_w = avs_address_in == FBE_OFS_MASK;
  assign hit_active_w = avs_address_in == FBE_OFS_ACTIVE;
  assign be_mask_w = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
    {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

  // One wait cycle: request taken in IDLE, completed in DONE
  assign avs_waitrequest_out = req_w & (state_q == FBE_IDLE);

  // Only the control word takes writes; status array ignores them
  assign rif.wr_ctrl = avs_write_in & (state_q == FBE_DONE) & hit_ctrl_w;
  assign rif.wdata = (avs_writedata_in & be_mask_w) |
    (rif.ctrl & ~be_mask_w);

  assign read_mux_w = hit_ctrl_w ? rif.ctrl :
    hit_count_w ? {24'h000000, FBE_RST_COUNT} :
    hit_mask_w ? rif.mask :
    hit_active_w ? rif.active :
    FBE_UNMAPPED_DATA;
  assign rdata_d = (avs_read_in && state_q == FBE_IDLE) ? read_mux_w : rdata_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      FBE_IDLE: begin
        if (req_w) begin
          state_d = FBE_DONE;
        end
      end
      FBE_DONE: begin
        state_d = FBE_IDLE;
      end
      default: begin
        state_d = FBE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= FBE_IDLE;
      rdata_q <= 32'h00000000;
      rvalid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rdata_q <= rdata_d;
      rvalid_q <= avs_read_in & (state_q == FBE_DONE);
    end
  end

  // Read data already stable in the cycle waitrequest drops
  assign avs_readdata_out = rdata_q;
  assign avs_readdatavalid_out = rvalid_q;
  assign active_flags_out = rif.active;

  chk_read_count: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (avs_read_in && hit_count_w && !avs_waitrequest_out) |->
    avs_readdata_out == 32'h00000002)
    else $error("entry count read wrong");
  chk_status_ro: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (avs_write_in && !hit_ctrl_w) |-> !rif.wr_ctrl)
    else $error("status element accepted a write");
  chk_wait_one: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (req_w && state_q == FBE_IDLE) |=> (req_w -> !avs_waitrequest_out))
    else $error("wait longer than one cycle");
  chk_ctrl_readback: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (avs_read_in && hit_ctrl_w && !avs_waitrequest_out) |->
    avs_readdata_out == rif.ctrl)
    else $error("control readback wrong");
endmodule

// ===== testbench/fbe_bank_bench.sv
// Self-checking bench for the fieldbus enable and status bank
`timescale 1ns/1ps
module fbe_bank_bench;
  import fbe_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdata;
  logic wait_o;
  logic rdv;
  logic [31:0] act;
  int fails = 0;
  int check_count = 0;
  always #5 clk_in = ~clk_in;
  fbe_bank fbe_bank_i (.clk_in(clk_in), .nrst_in(nrst_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_o),
    .avs_readdatavalid_out(rdv), .active_flags_out(act));
  task test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp, input string s);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask
  // Hold the request until waitrequest is sampled low, then release
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] b, output logic [31:0] q);
    int n;
    logic busy;
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    be <= b;
    rd <= !w;
    wr <= w;
    n = 0;
    // Sample settled mid-cycle; the transfer completes at the next edge
    do begin
      @(negedge clk_in);
      busy = wait_o;
      q = rdata;
      @(posedge clk_in);
      n++;
    end while (busy !== 1'b0 && n < 20);
    if (n >= 20) begin
      fails++;
      $display("unexpected at %0t: waitrequest never dropped", $time);
      test_done();
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    check(q, exp, "read data");
    @(negedge clk_in);
    check({31'h0, rdv}, 32'h1, "read valid");
  endtask
  task wr_word(input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    logic [31:0] q;
    bus(1'b1, a, d, b, q);
  endtask
  task scn_reset;
    rd_chk(FBE_OFS_CTRL, 32'h00190009);
    rd_chk(FBE_OFS_COUNT, {24'h0, FBE_RST_COUNT});
    rd_chk(FBE_OFS_MASK, 32'h00000008);
    rd_chk(FBE_OFS_ACTIVE, 32'h00190009);
    check(act, 32'h00190009, "active flags");
  endtask
  task scn_switch_can;
    // Lane 0 disabled: the CAN bit must not move
    wr_word(FBE_OFS_CTRL, 32'h0, 4'he);
    rd_chk(FBE_OFS_CTRL, 32'h00190009);
    wr_word(FBE_OFS_CTRL, 32'h00190001, 4'hf);
    rd_chk(FBE_OFS_CTRL, 32'h00190001);
    rd_chk(FBE_OFS_ACTIVE, 32'h00190001);
    check(act, 32'h00190001, "active flags");
  endtask
  task scn_locked_bits;
    wr_word(FBE_OFS_CTRL, 32'h0, 4'hf);
    rd_chk(FBE_OFS_ACTIVE, 32'h00190001);
    rd_chk(FBE_OFS_MASK, 32'h00000008);
    wr_word(FBE_OFS_CTRL, 32'hffffffff, 4'hf);
    rd_chk(FBE_OFS_CTRL, 32'h00190009);
    rd_chk(FBE_OFS_ACTIVE, 32'h00190009);
  endtask
  task scn_read_only;
    wr_word(FBE_OFS_COUNT, 32'h000000ff, 4'hf);
    wr_word(FBE_OFS_MASK, 32'hffffffff, 4'hf);
    wr_word(FBE_OFS_ACTIVE, 32'h0, 4'hf);
    rd_chk(FBE_OFS_COUNT, 32'h00000002);
    rd_chk(FBE_OFS_MASK, 32'h00000008);
    rd_chk(FBE_OFS_ACTIVE, 32'h00190009);
    wr_word(4'h2, 32'h0, 4'hf);
    rd_chk(4'h2, FBE_UNMAPPED_DATA);
    rd_chk(FBE_OFS_CTRL, 32'h00190009);
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    scn_reset();
    scn_switch_can();
    scn_locked_bits();
    scn_read_only();
    test_done();
  end
endmodule
